//--- hdl/cc_pkg.sv
package cc_pkg;

  localparam int unsigned N_UNIT      = 2;
  localparam int unsigned N_CH_UNIT   = 16;
  localparam int unsigned N_CH        = 32;
  localparam int unsigned N_TMR       = 4;
  localparam int unsigned N_EXT       = 2;
  localparam int unsigned PAIR_SPAN   = 8;
  localparam int unsigned PSC_W       = 10;
  localparam int unsigned PSC_MIN_DIV = 8;
  localparam int unsigned IN_ONLY_FIRST = 24;
  localparam int unsigned IN_ONLY_LAST  = 27;

  // Byte address map; every register is one aligned 32-bit word.
  localparam logic [9:0] OFS_CC_VAL  = 10'h000;
  localparam logic [9:0] OFS_CC_MODE = 10'h080;
  localparam logic [9:0] OFS_TMR     = 10'h100;
  localparam logic [9:0] OFS_REQ     = 10'h140;
  localparam logic [9:0] OFS_EN      = 10'h144;
  localparam logic [9:0] OFS_TREQ    = 10'h148;
  localparam logic [9:0] OFS_TEN     = 10'h14c;
  localparam logic [1:0] TREG_VALUE  = 2'h0;
  localparam logic [1:0] TREG_RELOAD = 2'h1;
  localparam logic [1:0] TREG_CTRL   = 2'h2;

  // Channel mode register fields.
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_W   = 4;
  localparam int unsigned TSEL_BIT = 4;
  // Timer control register fields.
  localparam int unsigned TIS_LSB  = 0;
  localparam int unsigned TIS_W    = 3;
  localparam int unsigned TSRC_LSB = 3;
  localparam int unsigned TSRC_W   = 2;
  localparam int unsigned TRUN_BIT = 5;

  localparam logic [15:0] RST_TIMER  = 16'h0000;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  localparam logic [15:0] TMR_TOP    = 16'hffff;
  localparam logic [5:0]  RST_TCTRL  = 6'h00;
  localparam logic [4:0]  RST_CMODE  = 5'h00;

  typedef enum logic [3:0] {
    MODE_OFF = 4'h0,
    CAP_RISE = 4'h1,
    CAP_FALL = 4'h2,
    CAP_BOTH = 4'h3,
    CMP_M0   = 4'h4,
    CMP_M1   = 4'h5,
    CMP_M2   = 4'h6,
    CMP_M3   = 4'h7,
    CMP_DBL  = 4'h8
  } cc_mode_e;

  typedef enum logic [1:0] {
    SRC_PSC = 2'h0,
    SRC_AUX = 2'h1,
    SRC_EXT = 2'h2
  } tmr_src_e;

  typedef struct packed {
    logic [9:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avmm_req_s;

endpackage

//--- hdl/dual_capture_compare_array.sv
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
// Contract
// - Two independent units of 16 capture/compare channels, 32 in total.
// - Each unit has two 16-bit timers, each with its own reload register.
// - Timer counts from a prescaled system clock or auxiliary timer overflow.
// - First timer of each unit can also count an external input.
// - Each channel selects either unit timer and capture or compare use.
// - Each channel owns one pin: capture input or compare output.
// - In unit two, channels 24 to 27 are capture inputs only.
// - A capture event copies the allocated timer into the channel register.
// - Every capture raises the channel interrupt request.
// - Capture edge is rising, falling or both, per channel.
// - Compare channels match continuously against the allocated timer.
// - Mode 0 raises only an interrupt, on every match.
// - Mode 1 toggles the pin on every match.
// - Mode 2 raises an interrupt at most once per timer period.
// - Mode 3 sets pin on match, clears on overflow, once per period.
// - Double mode: two registers toggle one shared pin on either match.
// - Both first timers fed the same input count in lockstep.
// - Reload zero gives a full 16-bit timer period.
// - Smallest prescaler option gives the finest timer resolution.
// - A 3-bit input select picks prescaler 8 up to 1024.
// - Each source has a request flag and an individual enable bit.
module dual_capture_compare_array
  import cc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire avmm_req_s         avm,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  input  wire logic              aux_overflow,
  input  wire logic [N_EXT-1:0]  ext_count_pin,
  input  wire logic [N_CH-1:0]   cc_pin_in,
  output logic [N_CH-1:0]        cc_pin_out,
  output logic [N_CH-1:0]        cc_pin_oe_n,
  output logic [N_CH+N_TMR-1:0]  request_pending
);

  localparam int unsigned NS = N_CH + N_EXT;

  logic [15:0]       val_q   [N_CH];
  logic [15:0]       val_d   [N_CH];
  logic [4:0]        cmode_q [N_CH];
  logic [4:0]        cmode_d [N_CH];
  logic [15:0]       tmr_q   [N_TMR];
  logic [15:0]       tmr_d   [N_TMR];
  logic [15:0]       rel_q   [N_TMR];
  logic [15:0]       rel_d   [N_TMR];
  logic [5:0]        tctl_q  [N_TMR];
  logic [5:0]        tctl_d  [N_TMR];
  logic [N_TMR-1:0]  upd_q;
  logic [N_TMR-1:0]  upd_d;
  logic [N_TMR-1:0]  ovf_q;
  logic [N_TMR-1:0]  ovf_d;
  logic [N_TMR-1:0]  tflag_q;
  logic [N_TMR-1:0]  tflag_d;
  logic [N_TMR-1:0]  ten_q;
  logic [N_TMR-1:0]  ten_d;
  logic [N_CH-1:0]   flag_q;
  logic [N_CH-1:0]   flag_d;
  logic [N_CH-1:0]   en_q;
  logic [N_CH-1:0]   en_d;
  logic [N_CH-1:0]   fired_q;
  logic [N_CH-1:0]   fired_d;
  logic [N_CH-1:0]   pin_q;
  logic [N_CH-1:0]   pin_d;
  logic [N_CH-1:0]   oen_q;
  logic [N_CH-1:0]   oen_d;
  logic [NS-1:0]     s1_q;
  logic [NS-1:0]     s2_q;
  logic [NS-1:0]     s3_q;
  logic [NS-1:0]     lvl_q;
  logic [NS-1:0]     lvl_d;
  logic [PSC_W-1:0]  psc_q;
  logic [PSC_W-1:0]  psc_d;
  logic              ack_q;
  logic              ack_d;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;

  // Divider mask for input select code sel: divide by 8 << sel.
  function automatic logic [PSC_W-1:0] psc_mask(input logic [2:0] sel);
    logic [PSC_W:0] div;
    div = (PSC_W+1)'(PSC_MIN_DIV) << sel;
    return PSC_W'(div - 1'b1);
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic input_only(input int ch);
    return (ch >= IN_ONLY_FIRST) && (ch <= IN_ONLY_LAST);
  endfunction

  always_comb begin
    logic [NS-1:0]    rise;
    logic [NS-1:0]    fall;
    logic             tick;
    logic             acc;
    logic [31:0]      wmask;
    logic [N_CH-1:0]  set;
    logic             hit;
    cc_mode_e         md;
    int               t;
    int               tgt;
    rise = '0;
    fall = '0;
    tick = 1'b0;
    wmask = '0;
    set = '0;
    hit = 1'b0;
    md = MODE_OFF;
    t = 0;
    tgt = 0;
    acc = (avm.read | avm.write) & ~ack_q;
    ack_d = acc;
    rdata_d = rdata_q;
    val_d = val_q;
    cmode_d = cmode_q;
    tmr_d = tmr_q;
    rel_d = rel_q;
    tctl_d = tctl_q;
    tflag_d = tflag_q;
    ten_d = ten_q;
    flag_d = flag_q;
    en_d = en_q;
    fired_d = fired_q;
    pin_d = pin_q;
    upd_d = '0;
    ovf_d = '0;
    psc_d = psc_q + 1'b1;

    // A pin level is accepted only once the second and third stages agree.
    lvl_d = lvl_q;
    for (int b = 0; b < NS; b++) begin
      if (s2_q[b] == s3_q[b]) begin
        lvl_d[b] = s2_q[b];
      end
      rise[b] = (s2_q[b] == s3_q[b]) & s2_q[b] & ~lvl_q[b];
      fall[b] = (s2_q[b] == s3_q[b]) & ~s2_q[b] & lvl_q[b];
    end

    for (int k = 0; k < N_TMR; k++) begin
      tick = 1'b0;
      if (tctl_q[k][TRUN_BIT]) begin
        case (tmr_src_e'(tctl_q[k][TSRC_LSB +: TSRC_W]))
          SRC_PSC: tick = (psc_q & psc_mask(tctl_q[k][TIS_LSB +: TIS_W]))
                          == psc_mask(tctl_q[k][TIS_LSB +: TIS_W]);
          SRC_AUX: tick = aux_overflow;
          SRC_EXT: tick = (k % 2 == 0) && rise[N_CH + k/2];
          default: tick = 1'b0;
        endcase
      end
      if (tick) begin
        upd_d[k] = 1'b1;
        if (tmr_q[k] == TMR_TOP) begin
          tmr_d[k] = rel_q[k];
          ovf_d[k] = 1'b1;
          tflag_d[k] = 1'b1;
        end else begin
          tmr_d[k] = tmr_q[k] + 1'b1;
        end
      end
    end

    // Register access; hardware sets below override software clears.
    if (acc) begin
      wmask = be_merge(32'h0000_0000, avm.writedata, avm.byteenable);
      rdata_d = 32'h0000_0000;
      if (avm.address[9:7] == OFS_CC_VAL[9:7]) begin
        if (avm.write) begin
          val_d[avm.address[6:2]] = 16'(be_merge({16'h0000,
            val_q[avm.address[6:2]]}, avm.writedata, avm.byteenable));
        end else begin
          rdata_d = {16'h0000, val_q[avm.address[6:2]]};
        end
      end else if (avm.address[9:7] == OFS_CC_MODE[9:7]) begin
        if (avm.write) begin
          cmode_d[avm.address[6:2]] = 5'(be_merge({27'h0,
            cmode_q[avm.address[6:2]]}, avm.writedata, avm.byteenable));
        end else begin
          rdata_d = {27'h0, cmode_q[avm.address[6:2]]};
        end
      end else if (avm.address[9:6] == OFS_TMR[9:6]) begin
        t = int'(avm.address[5:4]);
        case (avm.address[3:2])
          TREG_VALUE: begin
            if (avm.write) begin
              tmr_d[t] = 16'(be_merge({16'h0000, tmr_q[t]}, avm.writedata,
                                      avm.byteenable));
            end
            rdata_d = {16'h0000, tmr_q[t]};
          end
          TREG_RELOAD: begin
            if (avm.write) begin
              rel_d[t] = 16'(be_merge({16'h0000, rel_q[t]}, avm.writedata,
                                      avm.byteenable));
            end
            rdata_d = {16'h0000, rel_q[t]};
          end
          TREG_CTRL: begin
            if (avm.write) begin
              tctl_d[t] = 6'(be_merge({26'h0, tctl_q[t]}, avm.writedata,
                                      avm.byteenable));
            end
            rdata_d = {26'h0, tctl_q[t]};
          end
          default: rdata_d = 32'h0000_0000;
        endcase
        if (avm.write) begin
          rdata_d = 32'h0000_0000;
        end
      end else if (avm.address[9:4] == OFS_REQ[9:4]) begin
        case (avm.address[3:2])
          OFS_REQ[3:2]: begin
            if (avm.write) begin
              flag_d = flag_q & ~wmask;
            end else begin
              rdata_d = flag_q;
            end
          end
          OFS_EN[3:2]: begin
            if (avm.write) begin
              en_d = be_merge(en_q, avm.writedata, avm.byteenable);
            end else begin
              rdata_d = en_q;
            end
          end
          OFS_TREQ[3:2]: begin
            if (avm.write) begin
              tflag_d = tflag_d & ~wmask[N_TMR-1:0];
            end else begin
              rdata_d = {28'h0, tflag_q};
            end
          end
          default: begin
            if (avm.write) begin
              ten_d = N_TMR'(be_merge({28'h0, ten_q}, avm.writedata,
                                      avm.byteenable));
            end else begin
              rdata_d = {28'h0, ten_q};
            end
          end
        endcase
      end
    end
    // Overflow set after the clear so a coincident event is kept.
    tflag_d = tflag_d | ovf_d;

    for (int i = 0; i < N_CH; i++) begin
      t = (i / N_CH_UNIT) * 2 + int'(cmode_q[i][TSEL_BIT]);
      md = cc_mode_e'(cmode_q[i][MODE_LSB +: MODE_W]);
      hit = upd_q[t] && (tmr_q[t] == val_q[i]);
      if (ovf_q[t]) begin
        fired_d[i] = 1'b0;
      end
      case (md)
        CAP_RISE, CAP_FALL, CAP_BOTH: begin
          if ((md == CAP_RISE && rise[i]) || (md == CAP_FALL && fall[i]) ||
              (md == CAP_BOTH && (rise[i] || fall[i]))) begin
            val_d[i] = tmr_q[t];
            set[i] = 1'b1;
          end
        end
        CMP_M0: begin
          set[i] = hit;
        end
        CMP_M1: begin
          if (hit) begin
            pin_d[i] = ~pin_d[i];
            set[i] = 1'b1;
          end
        end
        CMP_M2: begin
          if (hit && !fired_q[i]) begin
            set[i] = 1'b1;
            fired_d[i] = 1'b1;
          end
        end
        CMP_M3: begin
          if (ovf_q[t]) begin
            pin_d[i] = 1'b0;
          end
          if (hit && !fired_q[i]) begin
            pin_d[i] = 1'b1;
            fired_d[i] = 1'b1;
            set[i] = 1'b1;
          end
        end
        CMP_DBL: begin
          // Channels k and k+8 of a unit share the pin of channel k.
          tgt = (i / N_CH_UNIT) * N_CH_UNIT + (i % PAIR_SPAN);
          if (hit) begin
            pin_d[tgt] = ~pin_d[tgt];
            set[i] = 1'b1;
          end
        end
        default: set[i] = 1'b0;
      endcase
    end
    flag_d = flag_d | set;

    for (int i = 0; i < N_CH; i++) begin
      md = cc_mode_e'(cmode_d[i][MODE_LSB +: MODE_W]);
      oen_d[i] = !(md == CMP_M1 || md == CMP_M3 || md == CMP_DBL);
      if ((i % N_CH_UNIT) < PAIR_SPAN) begin
        md = cc_mode_e'(cmode_d[i + PAIR_SPAN][MODE_LSB +: MODE_W]);
        if (md == CMP_DBL) begin
          oen_d[i] = 1'b0;
        end
      end
      if (input_only(i)) begin
        oen_d[i] = 1'b1;
        pin_d[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    s1_q <= {ext_count_pin, cc_pin_in};
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (srst) begin
      for (int i = 0; i < N_CH; i++) begin
        val_q[i]   <= 16'h0000;
        cmode_q[i] <= RST_CMODE;
      end
      for (int k = 0; k < N_TMR; k++) begin
        tmr_q[k]  <= RST_TIMER;
        rel_q[k]  <= RST_RELOAD;
        tctl_q[k] <= RST_TCTRL;
      end
      upd_q   <= '0;
      ovf_q   <= '0;
      tflag_q <= '0;
      ten_q   <= '0;
      flag_q  <= '0;
      en_q    <= '0;
      fired_q <= '0;
      pin_q   <= '0;
      oen_q   <= '1;
      lvl_q   <= '0;
      psc_q   <= '0;
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      val_q   <= val_d;
      cmode_q <= cmode_d;
      tmr_q   <= tmr_d;
      rel_q   <= rel_d;
      tctl_q  <= tctl_d;
      upd_q   <= upd_d;
      ovf_q   <= ovf_d;
      tflag_q <= tflag_d;
      ten_q   <= ten_d;
      flag_q  <= flag_d;
      en_q    <= en_d;
      fired_q <= fired_d;
      pin_q   <= pin_d;
      oen_q   <= oen_d;
      lvl_q   <= lvl_d;
      psc_q   <= psc_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // One wait cycle per access; the answer comes at the second edge.
  assign waitrequest     = (avm.read | avm.write) & ~ack_q;
  assign readdata        = rdata_q;
  assign cc_pin_out      = pin_q;
  assign cc_pin_oe_n     = oen_q;
  assign request_pending = {tflag_q & ten_q, flag_q & en_q};

endmodule

//--- bench/cc_checker_properties.sv
`timescale 1ns/10ps
module cc_checker
  import cc_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  srst,
  input wire avmm_req_s             avm,
  input wire logic [31:0]           readdata,
  input wire logic                  waitrequest,
  input wire logic [N_CH-1:0]       cc_pin_out,
  input wire logic [N_CH-1:0]       cc_pin_oe_n,
  input wire logic [N_CH+N_TMR-1:0] request_pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_req;
    (avm.read || avm.write) && waitrequest;
  endsequence
  sequence s_done;
    (avm.read || avm.write) && !waitrequest;
  endsequence
  AST_ONE_WAIT: assert property (s_req |=> !waitrequest)
    else $error("access not answered after one wait cycle");
  AST_WAIT_FIRST: assert property (s_done |-> $past(waitrequest))
    else $error("access answered without a wait cycle");
  AST_READ_HOLD: assert property ($changed(readdata) |->
    $past(avm.read || avm.write)) else $error("read data moved while idle");
  AST_UNMAPPED: assert property (s_done and avm.read && avm.address >= 10'h150
    |-> readdata == 32'h0) else $error("unmapped read not zero");
  AST_VAL_WIDTH: assert property (s_done and avm.read &&
    avm.address < OFS_CC_MODE |-> readdata[31:16] == 16'h0)
    else $error("channel value wider");
  AST_INONLY_OUT: assert property (cc_pin_out[27:24] == 4'h0)
    else $error("input-only channel drives a level");
  AST_INONLY_OE: assert property (cc_pin_oe_n[27:24] == 4'hf)
    else $error("input-only channel enables its driver");
  AST_OE_BY_WRITE: assert property ($changed(cc_pin_oe_n) |->
    $past(avm.write) || $past(avm.write, 2)) else $error("pin enable moved");
  AST_REQ_FALL: assert property (
    |($past(request_pending) & ~request_pending) |->
    $past(avm.write) || $past(avm.write, 2))
    else $error("pending request dropped without a write");
endmodule

//--- bench/cc_pin_partner.sv
`timescale 1ns/10ps
module cc_pin_partner
  import cc_pkg::*;
(
  input  wire logic         clk,
  output logic              aux_overflow,
  output logic [N_EXT-1:0]  ext_count_pin,
  output logic [N_CH-1:0]   cc_pin_in
);
  initial begin
    aux_overflow = 1'b0;
    ext_count_pin = '0;
    cc_pin_in = '0;
  end
  // With the default mask m one source feeds both count inputs, so both first timers see one event.
  task automatic ext_pulses(input int n,
                            input logic [N_EXT-1:0] m = '1);
    repeat (n) begin
      @(posedge clk);
      ext_count_pin <= m;
      repeat (4) @(posedge clk);
      ext_count_pin <= 2'h0;
      repeat (3) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic aux_pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      aux_overflow <= 1'b1;
      @(posedge clk);
      aux_overflow <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic set_pins(input logic [N_CH-1:0] v);
    @(posedge clk);
    cc_pin_in <= v;
    repeat (8) @(posedge clk);
  endtask
endmodule

//--- bench/test_dual_capture_compare_array.sv
`timescale 1ns/10ps
module test_dual_capture_compare_array
  import cc_pkg::*;
;
  logic                  clk;
  logic                  srst;
  avmm_req_s             avm;
  logic [31:0]           readdata;
  logic [31:0]           rd;
  logic [31:0]           r1;
  logic                  waitrequest;
  logic                  aux_overflow;
  logic [N_EXT-1:0]      ext_count_pin;
  logic [N_CH-1:0]       src_pins;
  logic [N_CH-1:0]       pin_level;
  logic [N_CH-1:0]       cc_pin_out;
  logic [N_CH-1:0]       cc_pin_oe_n;
  logic [N_CH+N_TMR-1:0] request_pending;
  int                    num_errors;
  int                    n_checks;

  // A driven pin reads back its own level, as on the real wire.
  assign pin_level = (cc_pin_oe_n & src_pins) | (~cc_pin_oe_n & cc_pin_out);

  dual_capture_compare_array uut (.clk(clk), .srst(srst), .avm(avm),
    .readdata(readdata), .waitrequest(waitrequest),
    .aux_overflow(aux_overflow), .ext_count_pin(ext_count_pin),
    .cc_pin_in(pin_level), .cc_pin_out(cc_pin_out),
    .cc_pin_oe_n(cc_pin_oe_n), .request_pending(request_pending));
  cc_pin_partner u_p (.clk(clk), .aux_overflow(aux_overflow),
    .ext_count_pin(ext_count_pin), .cc_pin_in(src_pins));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic complete_run;
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avm.address <= a;
    avm.read <= ~wr;
    avm.write <= wr;
    avm.writedata <= d;
    avm.byteenable <= be;
    // Waitrequest and read data are taken at the rising edge itself.
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    rd = readdata;
    if (n >= 40)
      num_errors++;
    avm.read <= 1'b0;
    avm.write <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    check(36'(rd), 36'(exp));
  endtask
  function automatic logic [9:0] ta(input int t, input logic [1:0] r);
    return OFS_TMR + 10'(t * 16) + {6'h0, r, 2'h0};
  endfunction
  function automatic logic [9:0] ch(input int c);
    return OFS_CC_VAL + 10'(c * 4);
  endfunction
  function automatic logic [31:0] ctrl(input tmr_src_e s, input int sel);
    return 32'({1'b1, s, 3'(sel)});
  endfunction

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  initial begin
    srst = 1'b1;
    avm = '0;
    num_errors = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rdc(ta(0, TREG_CTRL), 32'(RST_TCTRL));
    rdc(ta(3, TREG_RELOAD), 32'(RST_RELOAD));
    rdc(OFS_CC_MODE + 10'h7c, 32'(RST_CMODE));
    rdc(10'h3f0, 32'h0);
    wr(ch(31), 32'hffff5678);
    bus(1'b1, ch(31), 32'h0000ab00, 4'h2);
    rdc(ch(31), 32'hab78);
    wr(ta(0, TREG_CTRL), ctrl(SRC_EXT, 0));
    wr(ta(2, TREG_CTRL), ctrl(SRC_EXT, 0));
    u_p.ext_pulses(5);
    rdc(ta(0, TREG_VALUE), 32'h5);
    rdc(ta(2, TREG_VALUE), 32'h5);
    // Rising, falling and both-edge capture on channels 0 to 2.
    for (int i = 0; i < 3; i++)
      wr(OFS_CC_MODE + 10'(i * 4), 32'(i + 1));
    u_p.set_pins(32'h7);
    u_p.ext_pulses(2);
    u_p.set_pins(32'h0);
    rdc(ch(0), 32'h5);
    rdc(ch(1), 32'h7);
    rdc(ch(2), 32'h7);
    rdc(OFS_REQ, 32'h7);
    wr(OFS_REQ, 32'hffffffff);
    // Channels 4 to 7 take compare modes 0 to 3, all matching at 9.
    for (int i = 0; i < 4; i++) begin
      wr(ch(4 + i), 32'h9);
      wr(OFS_CC_MODE + 10'(16 + i * 4), 32'(CMP_M0) + 32'(i));
    end
    wr(ch(24), 32'h9);
    wr(OFS_CC_MODE + 10'(24 * 4), 32'(CMP_M1));
    u_p.ext_pulses(2);
    check(36'(cc_pin_out[4]), 36'h0);
    check(36'(cc_pin_out[5]), 36'h1);
    check(36'(cc_pin_oe_n[5]), 36'h0);
    check(36'(cc_pin_out[7]), 36'h1);
    check(36'(cc_pin_out[24]), 36'h0);
    rdc(OFS_REQ, 32'h010000f0);
    wr(OFS_REQ, 32'hffffffff);
    wr(ta(0, TREG_VALUE), 32'h8);
    u_p.ext_pulses(1);
    rdc(OFS_REQ, 32'h00000030);
    check(36'(cc_pin_out[5]), 36'h0);
    check(36'(cc_pin_out[7]), 36'h1);
    wr(ta(0, TREG_VALUE), 32'hfffe);
    u_p.ext_pulses(2);
    check(36'(cc_pin_out[7]), 36'h0);
    rdc(ta(0, TREG_VALUE), 32'h0);
    rdc(OFS_TREQ, 32'h1);
    wr(ta(0, TREG_RELOAD), 32'h1234);
    wr(ta(0, TREG_VALUE), 32'hffff);
    wr(ch(0), 32'h1235);
    wr(ch(8), 32'h1236);
    wr(OFS_CC_MODE, 32'(CMP_DBL));
    wr(OFS_CC_MODE + 10'h20, 32'(CMP_DBL));
    u_p.ext_pulses(1);
    rdc(ta(0, TREG_VALUE), 32'h1234);
    u_p.ext_pulses(1);
    check(36'(cc_pin_out[0]), 36'h1);
    u_p.ext_pulses(1);
    check(36'(cc_pin_out[0]), 36'h0);
    check(36'(cc_pin_out[8]), 36'h0);
    // Only the second unit's count input moves; the first timer holds.
    u_p.ext_pulses(1, 2'h2);
    rdc(ta(0, TREG_VALUE), 32'h1236);
    rdc(ta(2, TREG_VALUE), 32'h10);
    wr(OFS_EN, 32'h10);
    @(negedge clk);
    check(request_pending, 36'h10);
    wr(OFS_REQ, 32'h10);
    @(negedge clk);
    check(request_pending, 36'h0);
    wr(OFS_TEN, 32'h1);
    @(negedge clk);
    check(request_pending, 36'h100000000);
    wr(ta(3, TREG_CTRL), ctrl(SRC_AUX, 0));
    u_p.aux_pulses(6);
    rdc(ta(3, TREG_VALUE), 32'h6);
    wr(OFS_CC_MODE + 10'(16 * 4), 32'h11);
    u_p.set_pins(32'h10000);
    rdc(ch(16), 32'h6);
    wr(OFS_CC_MODE + 10'(25 * 4), 32'(CAP_BOTH));
    u_p.set_pins(32'h02010000);
    rdc(ch(25), 32'h10);
    // Ten ticks per code; the read overhead adds under one tick.
    for (int s = 0; s < 8; s++) begin
      wr(ta(1, TREG_CTRL), ctrl(SRC_PSC, s));
      bus(1'b0, ta(1, TREG_VALUE), 32'h0, 4'hf);
      r1 = rd;
      repeat (80 << s) @(posedge clk);
      bus(1'b0, ta(1, TREG_VALUE), 32'h0, 4'hf);
      check(36'((rd - r1) >= 9 && (rd - r1) <= 11), 36'h1);
    end
    complete_run();
  end
endmodule

bind dual_capture_compare_array cc_checker u_chk (.clk(clk), .srst(srst),
  .avm(avm), .readdata(readdata), .waitrequest(waitrequest),
  .cc_pin_out(cc_pin_out), .cc_pin_oe_n(cc_pin_oe_n),
  .request_pending(request_pending));
